/* File: src/sic_arbiter.sv */
// Acceptance and ranking of pending requests for the interrupt controller.
// Assumes all inputs come from the same clock domain; purely combinational.
`timescale 1ns/1ps
`include "sic_cfg.svh"

module sic_arbiter (
    input wire sic_pkg::sic_src_t pending, // Raw source requests
    input wire sic_pkg::sic_src_t srcEnable, // Per-source enable bits
    input wire sic_pkg::sic_src_t highLevel, // Per-source high-level bits
    input wire logic globalGate, // Global gate
    input wire logic priorityCircuitOff, // Priority circuit stopped
    input wire logic inSvcHigh, // High-level routine running
    input wire logic inSvcLow, // Low-level routine running
    output logic grant, // A request may be taken
    output sic_pkg::sic_idx_t grantIdx, // Chosen source index
    output logic grantHigh // Chosen source ranks high
);
    sic_pkg::sic_src_t req;
    sic_pkg::sic_src_t hiReq;
    sic_pkg::sic_src_t cand;

    // Lowest index wins: fixed order ext0, tmr0, ext1, tmr1, serial, tmr2
    function automatic sic_pkg::sic_idx_t firstSet(input sic_pkg::sic_src_t v);
        sic_pkg::sic_idx_t r;
        r = 3'h0;
        for (int i = `SIC_NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : firstSet

    always_comb begin
        req = pending & srcEnable & {`SIC_NSRC{globalGate}};
        hiReq = req & highLevel;
        if (priorityCircuitOff) begin
            cand = req;
        end else if (inSvcHigh) begin
            cand = '0;
        end else if (inSvcLow) begin
            cand = hiReq;
        end else if (|hiReq) begin
            cand = hiReq;
        end else begin
            cand = req;
        end
        grant = |cand;
        grantIdx = firstSet(cand);
        grantHigh = highLevel[grantIdx] & ~priorityCircuitOff;
    end
endmodule : sic_arbiter

/* File: src/sic_cfg.svh */
// Constants of the six-source interrupt controller: offsets, fields, resets.
// Assumes inclusion by bare name from every file that needs them.
`ifndef SIC_CFG_SVH
`define SIC_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define SIC_OFF_ENABLE 8'ha8
`define SIC_OFF_PRIO 8'hb8
`define SIC_OFF_STATUS 8'hc0
`define SIC_OFF_IRQMASK 8'hc4
`define SIC_OFF_SVC 8'hc8

// ****************************************
// Field positions and reset values
// ****************************************
`define SIC_BIT_GATE 7
`define SIC_BIT_PCT 7
`define SIC_BIT_SPARE 6
`define SIC_NSRC 6
`define SIC_CTL_RESET 8'h00
`define SIC_EVT_CALL 0
`define SIC_EVT_RETURN 1
`define SIC_EVT_PREEMPT 2
`define SIC_NEVT 3

// ****************************************
// Vector layout: base plus stride times source index
// ****************************************
`define SIC_VEC_BASE 16'h0003
`define SIC_VEC_STRIDE 16'h0008

`endif

/* File: src/sic_controller.sv */
// Six-source interrupt controller: registers on APB, ranking, CPU vectoring.
// Assumes requests and CPU strobes are synchronous to sys_clk.
`timescale 1ns/1ps
`include "sic_cfg.svh"

module sic_controller #(
    parameter int ADDR_W = 8
) (
    input wire logic sys_clk, // System clock, 20 MHz
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire sic_pkg::sic_src_t srcRequest, // Peripheral request levels
    output sic_pkg::sic_src_t srcAck, // Pulse: request taken
    input wire logic instrDone, // Pulse: an instruction completed
    input wire logic retiDone, // Pulse: completed one was return_from_handler
    output logic vectorCall, // Pulse: call vectorAddr now
    output logic [15:0] vectorAddr, // Address of the called routine
    output logic irq // Level: unmasked event pending
);
    // ****************************************
    // State: APB read side
    // ****************************************
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic slvErr_q;
    logic slvErr_d;

    // ****************************************
    // State: control registers and event flags
    // ****************************************
    sic_pkg::sic_src_t enBits_q;
    sic_pkg::sic_src_t enBits_d;
    logic gate_q;
    logic gate_d;
    sic_pkg::sic_src_t prioBits_q;
    sic_pkg::sic_src_t prioBits_d;
    logic pct_q;
    logic pct_d;
    logic [`SIC_NEVT-1:0] status_q;
    logic [`SIC_NEVT-1:0] status_d;
    logic [`SIC_NEVT-1:0] irqMask_q;
    logic [`SIC_NEVT-1:0] irqMask_d;

    // ****************************************
    // State: sequencer and in-service tracking
    // ****************************************
    logic inSvcHigh_q;
    logic inSvcHigh_d;
    logic inSvcLow_q;
    logic inSvcLow_d;
    logic [3:0] depth_q;
    logic [3:0] depth_d;
    sic_pkg::sic_seq_t seq_q;
    sic_pkg::sic_seq_t seq_d;
    logic call_q;
    logic call_d;
    logic [15:0] vec_q;
    logic [15:0] vec_d;
    sic_pkg::sic_src_t ack_q;
    sic_pkg::sic_src_t ack_d;
    sic_pkg::sic_idx_t lastIdx_q;
    sic_pkg::sic_idx_t lastIdx_d;

    // ****************************************
    // Internal nets
    // ****************************************
    logic setup;
    logic wrAccess;
    logic ctlWrite;
    logic grant;
    logic grantHigh;
    sic_pkg::sic_idx_t grantIdx;
    logic [`SIC_NEVT-1:0] evt;

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return a == ADDR_W'(`SIC_OFF_ENABLE) ||
               a == ADDR_W'(`SIC_OFF_PRIO) ||
               a == ADDR_W'(`SIC_OFF_STATUS) ||
               a == ADDR_W'(`SIC_OFF_IRQMASK) ||
               a == ADDR_W'(`SIC_OFF_SVC);
    endfunction : mapped

    function automatic logic [15:0] vectorOf(input sic_pkg::sic_idx_t idx);
        return 16'(`SIC_VEC_BASE + `SIC_VEC_STRIDE * 16'(idx));
    endfunction : vectorOf

    // ****************************************
    // Ranking of pending requests
    // ****************************************
    sic_arbiter u_arbiter (
        .pending(srcRequest),
        .srcEnable(enBits_q),
        .highLevel(prioBits_q),
        .globalGate(gate_q),
        .priorityCircuitOff(pct_q),
        .inSvcHigh(inSvcHigh_q),
        .inSvcLow(inSvcLow_q),
        .grant(grant),
        .grantIdx(grantIdx),
        .grantHigh(grantHigh)
    );

    // ****************************************
    // APB slave: zero wait states, read data captured in setup
    // ****************************************
    assign setup = psel & ~penable;
    assign wrAccess = psel & penable & pwrite;
    // Only the two control registers arm the one-instruction hold
    assign ctlWrite = wrAccess & (paddr == ADDR_W'(`SIC_OFF_ENABLE) || paddr == ADDR_W'(`SIC_OFF_PRIO));
    assign pready = 1'b1;
    // Flag taken at setup, so the access phase answers at once
    assign pslverr = psel & penable & slvErr_q;
    assign prdata = rdata_q;

    always_comb begin
        rdata_d = rdata_q;
        slvErr_d = slvErr_q;
        if (setup) begin
            slvErr_d = ~mapped(paddr);
            if (paddr == ADDR_W'(`SIC_OFF_ENABLE)) begin
                rdata_d = {24'h0, gate_q, 1'b1, enBits_q};
            end else if (paddr == ADDR_W'(`SIC_OFF_PRIO)) begin
                rdata_d = {24'h0, pct_q, 1'b1, prioBits_q};
            end else if (paddr == ADDR_W'(`SIC_OFF_STATUS)) begin
                rdata_d = {29'h0, status_q};
            end else if (paddr == ADDR_W'(`SIC_OFF_IRQMASK)) begin
                rdata_d = {29'h0, irqMask_q};
            end else if (paddr == ADDR_W'(`SIC_OFF_SVC)) begin
                rdata_d = {22'h0, lastIdx_q, depth_q, inSvcHigh_q, inSvcLow_q, 1'b0};
            end else begin
                rdata_d = 32'h0;
            end
        end
    end

    // ****************************************
    // Control registers and event flags
    // ****************************************
    always_comb begin
        enBits_d = enBits_q;
        gate_d = gate_q;
        prioBits_d = prioBits_q;
        pct_d = pct_q;
        irqMask_d = irqMask_q;
        status_d = status_q;
        if (wrAccess && paddr == ADDR_W'(`SIC_OFF_ENABLE)) begin
            enBits_d = pwdata[`SIC_NSRC-1:0];
            gate_d = pwdata[`SIC_BIT_GATE];
        end else if (wrAccess && paddr == ADDR_W'(`SIC_OFF_PRIO)) begin
            prioBits_d = pwdata[`SIC_NSRC-1:0];
            pct_d = pwdata[`SIC_BIT_PCT];
        end else if (wrAccess && paddr == ADDR_W'(`SIC_OFF_IRQMASK)) begin
            irqMask_d = pwdata[`SIC_NEVT-1:0];
        end else if (wrAccess && paddr == ADDR_W'(`SIC_OFF_STATUS)) begin
            status_d = status_q & ~pwdata[`SIC_NEVT-1:0];
        end
        // Set after clear so a same-cycle event is never lost
        status_d = status_d | evt;
    end

    // Level output; software drops it by clearing status bits
    assign irq = |(status_q & irqMask_q);

    // ****************************************
    // Sequencer: decides at each instruction boundary
    // ****************************************
    always_comb begin
        seq_d = seq_q;
        call_d = 1'b0;
        ack_d = '0;
        vec_d = vec_q;
        lastIdx_d = lastIdx_q;
        inSvcHigh_d = inSvcHigh_q;
        inSvcLow_d = inSvcLow_q;
        depth_d = depth_q;
        evt = '0;
        if (instrDone) begin
            if (retiDone) begin
                // Return also costs one instruction before the next call
                evt[`SIC_EVT_RETURN] = 1'b1;
                if (inSvcHigh_q) begin
                    inSvcHigh_d = 1'b0;
                end else begin
                    inSvcLow_d = 1'b0;
                end
                if (depth_q != 4'h0) begin
                    depth_d = depth_q - 4'h1;
                end
                seq_d = sic_pkg::SEQ_HOLD;
            end else if (seq_q == sic_pkg::SEQ_HOLD || ctlWrite) begin
                seq_d = ctlWrite ? sic_pkg::SEQ_HOLD : sic_pkg::SEQ_RUN;
            end else if (grant) begin
                call_d = 1'b1;
                vec_d = vectorOf(grantIdx);
                ack_d = sic_pkg::sic_src_t'(1) << grantIdx;
                lastIdx_d = grantIdx;
                evt[`SIC_EVT_CALL] = 1'b1;
                if (!pct_q) begin
                    evt[`SIC_EVT_PREEMPT] = inSvcLow_q;
                    if (grantHigh) begin
                        inSvcHigh_d = 1'b1;
                    end else begin
                        inSvcLow_d = 1'b1;
                    end
                end
                // Depth saturates; software nesting beyond 15 is not counted
                if (depth_q != 4'hf) begin
                    depth_d = depth_q + 4'h1;
                end
            end
        end else if (ctlWrite) begin
            seq_d = sic_pkg::SEQ_HOLD;
        end
    end

    assign vectorCall = call_q;
    assign vectorAddr = vec_q;
    assign srcAck = ack_q;

    // ****************************************
    // Registers: APB read side
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_q <= 32'h0;
            slvErr_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            slvErr_q <= slvErr_d;
        end
    end

    // ****************************************
    // Registers: control and event flags
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            enBits_q <= '0;
            gate_q <= 1'b0;
            prioBits_q <= '0;
            pct_q <= 1'b0;
            status_q <= '0;
            irqMask_q <= '0;
        end else begin
            enBits_q <= enBits_d;
            gate_q <= gate_d;
            prioBits_q <= prioBits_d;
            pct_q <= pct_d;
            status_q <= status_d;
            irqMask_q <= irqMask_d;
        end
    end

    // ****************************************
    // Registers: sequencer
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            inSvcHigh_q <= 1'b0;
            inSvcLow_q <= 1'b0;
            depth_q <= 4'h0;
            seq_q <= sic_pkg::SEQ_RUN;
            call_q <= 1'b0;
            vec_q <= 16'h0;
            ack_q <= '0;
            lastIdx_q <= 3'h0;
        end else begin
            inSvcHigh_q <= inSvcHigh_d;
            inSvcLow_q <= inSvcLow_d;
            depth_q <= depth_d;
            seq_q <= seq_d;
            call_q <= call_d;
            vec_q <= vec_d;
            ack_q <= ack_d;
            lastIdx_q <= lastIdx_d;
        end
    end
endmodule : sic_controller

/* File: src/sic_pkg.sv */
// Types shared by the interrupt controller files.
// Assumes sic_cfg.svh sits on the include path.
`include "sic_cfg.svh"

package sic_pkg;
    typedef logic [`SIC_NSRC-1:0] sic_src_t;
    typedef logic [2:0] sic_idx_t;
    typedef enum logic {SEQ_RUN, SEQ_HOLD} sic_seq_t;
endpackage : sic_pkg

/* File: verification/sic_controller_monitor.sv */
// Port checker for the interrupt controller.
// Assumes a bind from the bench; it sees only top-level ports.
`timescale 1ns/1ps
module sic_controller_monitor #(
    parameter int ADDR_W = 8
) (
    input wire logic sys_clk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [ADDR_W-1:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire sic_pkg::sic_src_t srcRequest, // Requests
    input wire sic_pkg::sic_src_t srcAck, // Taken
    input wire logic instrDone, // Completion
    input wire logic retiDone, // Return
    input wire logic vectorCall, // Call
    input wire logic [15:0] vectorAddr // Vector
);
    logic [7:0] ieQ;
    logic [7:0] ieD;
    logic holdQ;
    logic holdD;
    logic cfgAddr;
    logic cfgWr;
    logic [15:0] expAddr;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    assign cfgAddr = paddr == ADDR_W'(8'ha8) || paddr == ADDR_W'(8'hb8);
    assign cfgWr = psel && penable && pwrite && cfgAddr;
    // Shadow enable register; hold is dropped only by a plain completion
    always_comb begin
        ieD = (cfgWr && paddr == ADDR_W'(8'ha8)) ? pwdata[7:0] : ieQ;
        holdD = holdQ;
        if (cfgWr || (instrDone && retiDone)) holdD = 1'b1;
        else if (instrDone) holdD = 1'b0;
        expAddr = 16'h0000;
        for (int i = 0; i < 6; i++) begin
            if (srcAck[i]) expAddr = 16'h0003 + 16'(8 * i);
        end
    end
    always_ff @(posedge sys_clk) begin
        ieQ <= sys_rst ? 8'h00 : ieD;
        holdQ <= sys_rst ? 1'b0 : holdD;
    end
    sequence cfgHeld;
        instrDone && (holdQ || cfgWr);
    endsequence
    sequence retDone;
        instrDone && retiDone;
    endsequence
    a_vector_addr: assert property (vectorCall |-> $onehot(srcAck) && vectorAddr == expAddr)
        else $error("vector address wrong");
    a_ack_with_call: assert property ((|srcAck) == vectorCall)
        else $error("ack and call differ");
    a_call_after_done: assert property (vectorCall |-> $past(instrDone) && !$past(retiDone))
        else $error("call without completion");
    a_enable_gate: assert property (vectorCall |-> $past(ieQ[7]) && (srcAck & ~$past(ieQ[5:0])) == '0)
        else $error("disabled source called");
    a_ack_requested: assert property (vectorCall |-> (srcAck & ~$past(srcRequest)) == '0)
        else $error("unrequested source called");
    a_spare_reads_one: assert property (psel && penable && !pwrite && cfgAddr |-> prdata[6])
        else $error("spare bit read zero");
    a_hold_one_instr: assert property (cfgHeld |=> !vectorCall)
        else $error("call during hold");
    a_return_from_handler_no_call: assert property (retDone |=> !vectorCall)
        else $error("call on return");
endmodule : sic_controller_monitor

/* File: verification/sic_controller_tb.sv */
// Bench for the interrupt controller: APB tasks plus CPU model.
// Assumes the controller, its package and the CPU model are compiled first.
`timescale 1ns/1ps
module sic_controller_tb;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, instrDone, retiDone, vectorCall, irq, rdErr;
    sic_pkg::sic_src_t srcRequest, srcAck;
    sic_pkg::sic_src_t raiseReq = '0;
    logic stepReq = 1'b0;
    logic retiReq = 1'b0;
    logic [15:0] vectorAddr;
    int errCount = 0;
    int totalChecks = 0;
    always #25 sys_clk = ~sys_clk;
    sic_controller #(.ADDR_W(8)) dut_u (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .srcRequest, .srcAck, .instrDone, .retiDone, .vectorCall, .vectorAddr, .irq);
    sic_cpu_model cpu_u (.sys_clk, .sys_rst, .raiseReq, .stepReq, .retiReq, .srcAck, .srcRequest, .instrDone,
        .retiDone);
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Access lasts until pready is seen high; only the watchdog ends a hang
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rdChk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check("register", rd, exp);
    endtask : rdChk
    task raise(input sic_pkg::sic_src_t m);
        @(posedge sys_clk);
        raiseReq <= m;
        @(posedge sys_clk);
        raiseReq <= '0;
    endtask : raise
    // One instruction; the call stands in the cycle after the deciding edge
    task step(input logic r, input logic expCall, input logic [15:0] expAddr);
        @(posedge sys_clk);
        stepReq <= 1'b1;
        retiReq <= r;
        @(posedge sys_clk);
        stepReq <= 1'b0;
        retiReq <= 1'b0;
        @(posedge sys_clk);
        // Sample mid-cycle: the one-cycle pulse drops at the next rising edge
        @(negedge sys_clk);
        check("call", vectorCall, expCall);
        if (expCall) check("vector", vectorAddr, expAddr);
    endtask : step
    task testDone;
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : testDone
    initial begin
        #(50 * 20000);
        errCount++;
        testDone();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rdChk(8'ha8, 32'h40);
        rdChk(8'hb8, 32'h40);
        apb(1'b1, 8'ha8, 32'hff);
        rdChk(8'ha8, 32'hff);
        check("mapped error", rdErr, 1'b0);
        apb(1'b1, 8'hb8, 32'h3f);
        rdChk(8'hb8, 32'h7f);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped error", rdErr, 1'b1);
        $display("test registers done");
        apb(1'b1, 8'ha8, 32'h3f);
        apb(1'b1, 8'hb8, 32'h00);
        raise(6'h3f);
        step(1'b0, 1'b0, 16'h0);
        step(1'b0, 1'b0, 16'h0);
        apb(1'b1, 8'ha8, 32'ha0);
        step(1'b0, 1'b0, 16'h0);
        step(1'b0, 1'b1, 16'h002b);
        apb(1'b1, 8'ha8, 32'hbf);
        step(1'b0, 1'b0, 16'h0);
        step(1'b0, 1'b0, 16'h0);
        for (int i = 0; i < 5; i++) begin
            step(1'b1, 1'b0, 16'h0);
            step(1'b0, 1'b0, 16'h0);
            step(1'b0, 1'b1, 16'h0003 + 16'(8 * i));
        end
        step(1'b1, 1'b0, 16'h0);
        $display("test single level done");
        apb(1'b1, 8'hc4, 32'h04);
        apb(1'b1, 8'hb8, 32'h04);
        raise(6'h3f);
        step(1'b0, 1'b0, 16'h0);
        step(1'b0, 1'b1, 16'h0013);
        step(1'b0, 1'b0, 16'h0);
        step(1'b1, 1'b0, 16'h0);
        step(1'b0, 1'b0, 16'h0);
        step(1'b0, 1'b1, 16'h0003);
        check("irq masked", irq, 1'b0);
        raise(6'h04);
        step(1'b0, 1'b1, 16'h0013);
        check("irq set", irq, 1'b1);
        rdChk(8'hc8, 32'h116);
        apb(1'b0, 8'hc0, 32'h0);
        check("preempt status", rd[2], 1'b1);
        apb(1'b1, 8'hc0, 32'h07);
        @(posedge sys_clk);
        check("irq cleared", irq, 1'b0);
        step(1'b0, 1'b0, 16'h0);
        step(1'b1, 1'b0, 16'h0);
        step(1'b0, 1'b0, 16'h0);
        step(1'b0, 1'b0, 16'h0);
        step(1'b1, 1'b0, 16'h0);
        step(1'b0, 1'b0, 16'h0);
        step(1'b0, 1'b1, 16'h000b);
        $display("test two levels done");
        apb(1'b1, 8'hb8, 32'h80);
        step(1'b0, 1'b0, 16'h0);
        step(1'b0, 1'b1, 16'h001b);
        apb(1'b1, 8'ha8, 32'h3f);
        step(1'b0, 1'b0, 16'h0);
        step(1'b0, 1'b0, 16'h0);
        apb(1'b1, 8'ha8, 32'h90);
        step(1'b0, 1'b0, 16'h0);
        step(1'b0, 1'b1, 16'h0023);
        $display("test circuit off done");
        testDone();
    end
endmodule : sic_controller_tb
bind sic_controller sic_controller_monitor #(.ADDR_W(ADDR_W)) mon_u (.sys_clk, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .srcRequest, .srcAck, .instrDone, .retiDone, .vectorCall, .vectorAddr);

/* File: verification/sic_cpu_model.sv */
// CPU sequencer and peripheral request flags facing the controller.
// Assumes the bench pulses its commands just after rising edges.
`timescale 1ns/1ps
module sic_cpu_model (
    input wire logic sys_clk, // Clock
    input wire logic sys_rst, // Reset
    input wire sic_pkg::sic_src_t raiseReq, // Set request flags
    input wire logic stepReq, // Finish one instruction
    input wire logic retiReq, // It is a return
    input wire sic_pkg::sic_src_t srcAck, // Taken requests
    output sic_pkg::sic_src_t srcRequest, // Request levels
    output logic instrDone, // Completion pulse
    output logic retiDone // Return qualifier
);
    // Flags stay up until taken, as a peripheral's do
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            srcRequest <= '0;
            instrDone <= 1'b0;
            retiDone <= 1'b0;
        end else begin
            srcRequest <= (srcRequest & ~srcAck) | raiseReq;
            instrDone <= stepReq;
            retiDone <= stepReq && retiReq;
        end
    end
endmodule : sic_cpu_model
